/* design/mpfc_regs.sv */
// Purpose: Vendor fault configuration registers with derived thresholds.
// Assumes: A command decoder presents one-cycle write and read strobes with a code.
// Notes:   Derived outputs are registered so every output comes from a flip-flop.
`timescale 1ns/1ns
module mpfc_regs #(
    parameter logic [2:0] HW_PHASE_CODE = 3'h5
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    input  wire logic [7:0]  cmd,
    input  wire logic [15:0] wr_data,
    input  wire logic        status_clr,
    input  wire logic        table_sel,
    input  wire logic [15:0] output_setpoint,
    input  wire logic [15:0] output_ceiling,
    input  wire logic [15:0] droop_mv,
    input  wire logic [7:0]  max_dev_amps,
    input  wire logic [5:0]  dev_phase,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic      [2:0]  active_phase_code,
    output logic      [5:0]  phase_off,
    output logic             imb_status,
    output logic             vendor_status,
    output logic             bus_alert_line,
    output logic      [15:0] tracking_ov_mv,
    output logic      [15:0] fixed_ov_mv,
    output logic      [15:0] undervoltage_trip_mv,
    output logic      [15:0] boot_mv
);
    logic [7:0]  imb_q;
    logic [2:0]  phase_q;
    logic [4:0]  ov_q;
    logic [2:0]  uv_q;
    logic [7:0]  boot_q;
    logic [7:0]  thr_a;
    logic [15:0] uv_margin;
    logic [15:0] uv_trip;
    logic        imb_evt;
    logic        bad_phase_wr;

    assign bad_phase_wr = wr_stb && cmd == mpfc_pkg::CMD_PHASE_LIMIT
                          && wr_data[2:0] > HW_PHASE_CODE;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            imb_q  <= mpfc_pkg::RST_IMBALANCE;
            ov_q   <= mpfc_pkg::RST_OV_MARGINS[4:0];
            uv_q   <= mpfc_pkg::RST_UV_MARGIN[2:0];
            boot_q <= mpfc_pkg::RST_BOOT_CODE;
        end else if (wr_stb) begin
            unique case (cmd)
                mpfc_pkg::CMD_IMBALANCE: imb_q <= {wr_data[7], 4'h0, wr_data[2:0]};
                mpfc_pkg::CMD_OV_MARGINS: ov_q <= wr_data[4:0];
                mpfc_pkg::CMD_UV_MARGIN:  uv_q <= wr_data[2:0];
                mpfc_pkg::CMD_BOOT_CODE:  boot_q <= wr_data[7:0];
                default: ;
            endcase
        end
    end

    // Out-of-range requests leave the running count untouched.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= 3'h0;
        end else if (wr_stb && cmd == mpfc_pkg::CMD_PHASE_LIMIT && !bad_phase_wr) begin
            phase_q <= wr_data[2:0];
        end
    end

    // The hardware phase count is not known until reset ends, so it is loaded once after.
    logic loaded_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active_phase_code <= 3'h0;
        end else begin
            active_phase_code <= loaded_q ? phase_q : HW_PHASE_CODE;
        end
    end

    always_comb begin
        unique case (imb_q[2:0])
            3'h0:    thr_a = 8'h02;
            3'h1:    thr_a = 8'h04;
            3'h2:    thr_a = 8'h06;
            3'h3:    thr_a = 8'h08;
            3'h4:    thr_a = 8'h0a;
            3'h5:    thr_a = 8'h0f;
            3'h6:    thr_a = 8'h14;
            default: thr_a = mpfc_pkg::IMB_OFF;
        endcase
    end

    assign imb_evt = thr_a != mpfc_pkg::IMB_OFF && max_dev_amps > thr_a;

    // Set wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            imb_status    <= 1'b0;
            vendor_status <= 1'b0;
        end else begin
            imb_status    <= imb_evt | (imb_status & ~status_clr);
            vendor_status <= bad_phase_wr | (vendor_status & ~status_clr);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_alert_line <= 1'b0;
        end else begin
            bus_alert_line <= imb_evt | bad_phase_wr
                | ((imb_status | vendor_status) & ~status_clr);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_off <= 6'h00;
        end else if (imb_evt && !imb_q[mpfc_pkg::KEEP_BIT]) begin
            phase_off <= phase_off | dev_phase;
        end
    end

    mpfc_uv_decode u_uv (
        .code        (uv_q),
        .setpoint_mv (output_setpoint),
        .droop_mv    (droop_mv),
        .margin_mv   (uv_margin),
        .trip_mv     (uv_trip)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tracking_ov_mv       <= 16'h0000;
            fixed_ov_mv          <= 16'h0000;
            undervoltage_trip_mv <= 16'h0000;
            boot_mv              <= 16'h0000;
        end else begin
            tracking_ov_mv <= output_setpoint + mpfc_pkg::TRACK_BASE_MV
                + 16'(ov_q[4:3] * mpfc_pkg::TRACK_STEP_MV);
            fixed_ov_mv <= output_ceiling
                + 16'((ov_q[2:0] + 4'h1) * mpfc_pkg::FIX_STEP_MV);
            undervoltage_trip_mv <= uv_trip;
            // Table 0 steps 5 mV from 245 mV; table 1 steps 10 mV from 490 mV; code 0 is off.
            if (boot_q == 8'h00) begin
                boot_mv <= 16'h0000;
            end else if (table_sel) begin
                boot_mv <= 16'h01e0 + 16'(boot_q) * 16'h000a;
            end else begin
                boot_mv <= 16'h00f0 + 16'(boot_q) * 16'h0005;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_stb;
            unique case (cmd)
                mpfc_pkg::CMD_IMBALANCE:   rd_data <= {8'h00, imb_q};
                mpfc_pkg::CMD_PHASE_LIMIT: rd_data <= {13'h0000, phase_q};
                mpfc_pkg::CMD_OV_MARGINS:  rd_data <= {11'h000, ov_q};
                mpfc_pkg::CMD_UV_MARGIN:   rd_data <= {13'h0000, uv_q};
                mpfc_pkg::CMD_BOOT_CODE:   rd_data <= {8'h00, boot_q};
                default:                   rd_data <= 16'h0000;
            endcase
        end
    end

    property p_reject;
        @(posedge clk) disable iff (!rst_b)
        bad_phase_wr |=> vendor_status && bus_alert_line && phase_q == $past(phase_q);
    endproperty
    a_reject: assert property (p_reject) else $error("bad phase write not rejected");

    property p_accept;
        @(posedge clk) disable iff (!rst_b)
        wr_stb && cmd == mpfc_pkg::CMD_PHASE_LIMIT && wr_data[2:0] <= HW_PHASE_CODE
        |=> ##1 active_phase_code == $past(wr_data[2:0], 2);
    endproperty
    a_accept: assert property (p_accept) else $error("phase limit not applied");

    property p_imb;
        @(posedge clk) disable iff (!rst_b)
        imb_evt |=> imb_status && bus_alert_line;
    endproperty
    a_imb: assert property (p_imb) else $error("imbalance not flagged");

    property p_off;
        @(posedge clk) disable iff (!rst_b)
        imb_q[2:0] == 3'h7 |-> !imb_evt;
    endproperty
    a_off: assert property (p_off) else $error("disabled detection fired");

    property p_keep;
        @(posedge clk) disable iff (!rst_b)
        imb_evt && imb_q[mpfc_pkg::KEEP_BIT] |=> phase_off == $past(phase_off);
    endproperty
    a_keep: assert property (p_keep) else $error("kept phase turned off");

    property p_shed;
        @(posedge clk) disable iff (!rst_b)
        imb_evt && !imb_q[mpfc_pkg::KEEP_BIT] |=> (phase_off & $past(dev_phase)) == $past(dev_phase);
    endproperty
    a_shed: assert property (p_shed) else $error("faulty phase not turned off");

    property p_thr8;
        @(posedge clk) disable iff (!rst_b)
        imb_q[2:0] == 3'h3 && max_dev_amps == 8'h09 |-> imb_evt;
    endproperty
    a_thr8: assert property (p_thr8) else $error("8 A threshold wrong");

    property p_boot_hi;
        @(posedge clk) disable iff (!rst_b)
        rd_valid && $past(cmd) == mpfc_pkg::CMD_BOOT_CODE |-> rd_data[15:8] == 8'h00;
    endproperty
    a_boot_hi: assert property (p_boot_hi) else $error("boot high byte not zero");

    property p_ov_fix;
        @(posedge clk) disable iff (!rst_b)
        rst_b && ov_q[2:0] == 3'h7 && $stable(output_ceiling) && $stable(ov_q)
        |=> fixed_ov_mv == output_ceiling + 16'h0190;
    endproperty
    a_ov_fix: assert property (p_ov_fix) else $error("fixed OV margin wrong");

    // Derived outputs are one edge behind, so the edge that leaves reset is excluded.
    property p_track;
        @(posedge clk) disable iff (!rst_b)
        rst_b && ov_q[4:3] == 2'h3 |=> tracking_ov_mv == $past(output_setpoint) + 16'h0145;
    endproperty
    a_track: assert property (p_track) else $error("tracking OV margin wrong");

    property p_uv_top;
        @(posedge clk) disable iff (!rst_b)
        uv_q == 3'h7 |-> uv_margin == 16'h0190;
    endproperty
    a_uv_top: assert property (p_uv_top) else $error("UV margin top code wrong");

    property p_uv_trip;
        @(posedge clk) disable iff (!rst_b)
        rst_b && {1'b0, output_setpoint} >= {1'b0, droop_mv} + {1'b0, uv_margin}
        |=> undervoltage_trip_mv == $past(output_setpoint) - $past(droop_mv) - $past(uv_margin);
    endproperty
    a_uv_trip: assert property (p_uv_trip) else $error("UV trip level wrong");

    property p_boot_rd;
        @(posedge clk) disable iff (!rst_b)
        rd_stb && cmd == mpfc_pkg::CMD_BOOT_CODE |=> rd_data == {8'h00, $past(boot_q)};
    endproperty
    a_boot_rd: assert property (p_boot_rd) else $error("boot code readback wrong");

    property p_boot_off;
        @(posedge clk) disable iff (!rst_b)
        rst_b && boot_q == 8'h00 |=> boot_mv == 16'h0000;
    endproperty
    a_boot_off: assert property (p_boot_off) else $error("boot code zero not off");

    property p_clr;
        @(posedge clk) disable iff (!rst_b)
        status_clr && !imb_evt |=> !imb_status;
    endproperty
    a_clr: assert property (p_clr) else $error("imbalance status not cleared");

    property p_vendor_hold;
        @(posedge clk) disable iff (!rst_b)
        vendor_status && !status_clr |=> vendor_status;
    endproperty
    a_vendor_hold: assert property (p_vendor_hold) else $error("vendor status lost");

    c_reject: cover property (@(posedge clk) disable iff (!rst_b) bad_phase_wr);
    c_keep:   cover property (@(posedge clk) disable iff (!rst_b) imb_evt && imb_q[7]);
    c_imb:    cover property (@(posedge clk) disable iff (!rst_b) imb_evt);
    c_clr:    cover property (@(posedge clk) disable iff (!rst_b) imb_status ##1 !imb_status);
endmodule : mpfc_regs

/* design/mpfc_pkg.sv */
// Purpose: Shared constants for the multiphase fault configuration register bank.
// Assumes: Registers are addressed by 8-bit command codes on the management bus.
// Notes:   Voltages are in millivolts, currents in amperes.
package mpfc_pkg;
    localparam logic [7:0] CMD_IMBALANCE    = 8'he3;
    localparam logic [7:0] CMD_PHASE_LIMIT  = 8'he4;
    localparam logic [7:0] CMD_OV_MARGINS   = 8'he5;
    localparam logic [7:0] CMD_UV_MARGIN    = 8'he6;
    localparam logic [7:0] CMD_BOOT_CODE    = 8'he7;
    localparam logic [7:0] RST_IMBALANCE    = 8'h03;
    localparam logic [7:0] RST_OV_MARGINS   = 8'h0f;
    localparam logic [7:0] RST_UV_MARGIN    = 8'h03;
    localparam logic [7:0] RST_BOOT_CODE    = 8'h00;
    localparam int         KEEP_BIT         = 7;
    localparam int         TRACK_LSB        = 3;
    localparam int         STATUS_BIT       = 3;
    localparam logic [2:0] PHASE_CODE_MAX   = 3'h5;
    localparam logic [15:0] TRACK_BASE_MV   = 16'h00af;
    localparam logic [15:0] TRACK_STEP_MV   = 16'h0032;
    localparam logic [15:0] FIX_STEP_MV     = 16'h0032;
    // Threshold is reported in amperes; zero means detection off.
    localparam logic [7:0] IMB_OFF          = 8'h00;
endpackage : mpfc_pkg

/* design/mpfc_uv_decode.sv */
// Purpose: Undervoltage margin decode and trip level computation.
// Assumes: Load line in micro-ohms and current in amperes give millivolt drop / 1000.
// Notes:   Result saturates at zero.
`timescale 1ns/1ns
module mpfc_uv_decode (
    input  wire logic [2:0]  code,
    input  wire logic [15:0] setpoint_mv,
    input  wire logic [15:0] droop_mv,
    output logic      [15:0] margin_mv,
    output logic      [15:0] trip_mv
);
    logic [16:0] sub;
    always_comb begin
        unique case (code)
            3'h6:    margin_mv = 16'h0145;
            3'h7:    margin_mv = 16'h0190;
            default: margin_mv = (16'(code) + 16'h0001) * 16'h0032;
        endcase
        sub = {1'b0, setpoint_mv} - {1'b0, droop_mv} - {1'b0, margin_mv};
        trip_mv = sub[16] ? 16'h0000 : sub[15:0];
    end
endmodule : mpfc_uv_decode

/* tb/mpfc_host.sv */
// Purpose: Management bus host model that issues register writes and reads.
// Assumes: Strobes and command are sampled on the rising clock edge.
// Notes:   The command is held after a read because read data follows it.
`timescale 1ns/1ns
module mpfc_host (
    input  wire logic        clk,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic      [7:0]  cmd,
    output logic      [15:0] wr_data
);
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        cmd = 8'h00;
        wr_data = 16'h0000;
    end
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        if (c == mpfc_pkg::CMD_PHASE_LIMIT && d[2:0] > mpfc_pkg::PHASE_CODE_MAX) begin
            d[2:0] = mpfc_pkg::PHASE_CODE_MAX;
        end
        @(posedge clk);
        cmd <= c;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] c);
        @(posedge clk);
        cmd <= c;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
    endtask : rd
endmodule : mpfc_host

/* tb/mpfc_regs_tb.sv */
// Purpose: Self-checking bench for the fault configuration register bank.
// Assumes: Hardware provides four phases, so codes 4 and 5 are refused.
// Notes:   Derived outputs are checked three cycles after the write.
`timescale 1ns/1ns
module mpfc_regs_tb;
    logic clk = 1'b0, rst_b = 1'b0, status_clr = 1'b0, table_sel = 1'b0;
    logic wr_stb, rd_stb, rd_valid, imb_status, vendor_status, bus_alert_line;
    logic [7:0] cmd, max_dev_amps = 8'h00;
    logic [15:0] wr_data, rd_data, tracking_ov_mv, fixed_ov_mv, undervoltage_trip_mv, boot_mv;
    logic [15:0] output_setpoint = 16'd1000, output_ceiling = 16'd1500, droop_mv = 16'd20;
    logic [5:0] dev_phase = 6'h02, phase_off;
    logic [2:0] active_phase_code;
    logic [31:0] lfsr = 32'd97341;
    logic [7:0] boot_code;
    logic [15:0] exp_q[$];
    int bad_count = 0, checked = 0;
    int amps[7] = '{2, 4, 6, 8, 10, 15, 20};
    int uv[8] = '{50, 100, 150, 200, 250, 300, 325, 400};
    logic [15:0] masks[4] = '{16'h0087, 16'h001f, 16'h0007, 16'h00ff};
    logic [7:0] cmds[4] = '{8'he3, 8'he5, 8'he6, 8'he7};
    always #2 clk = ~clk;
    mpfc_host host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd(cmd), .wr_data(wr_data));
    mpfc_regs #(.HW_PHASE_CODE(3'h3)) dut (.clk(clk), .rst_b(rst_b), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .cmd(cmd), .wr_data(wr_data), .status_clr(status_clr),
        .table_sel(table_sel), .output_setpoint(output_setpoint),
        .output_ceiling(output_ceiling), .droop_mv(droop_mv), .max_dev_amps(max_dev_amps),
        .dev_phase(dev_phase), .rd_data(rd_data), .rd_valid(rd_valid),
        .active_phase_code(active_phase_code), .phase_off(phase_off),
        .imb_status(imb_status), .vendor_status(vendor_status),
        .bus_alert_line(bus_alert_line), .tracking_ov_mv(tracking_ov_mv),
        .fixed_ov_mv(fixed_ov_mv), .undervoltage_trip_mv(undervoltage_trip_mv),
        .boot_mv(boot_mv));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd_exp(input logic [7:0] c, input logic [15:0] e);
        exp_q.push_back(e);
        host.rd(c);
    endtask : rd_exp
    task automatic clr_status();
        @(posedge clk);
        status_clr <= 1'b1;
        @(posedge clk);
        status_clr <= 1'b0;
    endtask : clr_status
    // Read answers are matched in order of issue, so a lost or extra answer shows up.
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected read", 16'h0000, 16'hffff);
            else chk("read data", exp_q.pop_front(), rd_data);
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd_exp(8'he3, 16'h0003);
        rd_exp(8'he5, 16'h000f);
        rd_exp(8'he6, 16'h0003);
        rd_exp(8'he7, 16'h0000);
        rd_exp(8'he2, 16'h0000);
        $display("test reset values done");
        for (int k = 0; k < 16; k++) begin
            lfsr = next_rand(lfsr);
            table_sel <= lfsr[9];
            host.wr(cmds[k % 4], lfsr[15:0]);
            rd_exp(cmds[k % 4], lfsr[15:0] & masks[k % 4]);
        end
        host.wr(8'he2, lfsr[15:0]);
        rd_exp(8'he2, 16'h0000);
        $display("test readback done");
        for (int i = 0; i < 8; i++) begin
            host.wr(8'he5, 16'(i % 4 * 8 + i));
            host.wr(8'he6, 16'(i));
            repeat (3) @(posedge clk);
            chk("tracking ov", 16'(1175 + 50 * (i % 4)), tracking_ov_mv);
            chk("fixed ov", 16'(1550 + 50 * i), fixed_ov_mv);
            chk("uv trip", 16'(980 - uv[i]), undervoltage_trip_mv);
        end
        $display("test thresholds done");
        for (int t = 0; t < 3; t++) begin
            lfsr = next_rand(lfsr);
            boot_code = (t == 2) ? 8'h00 : lfsr[7:0];
            table_sel <= t[0];
            host.wr(8'he7, {8'h00, boot_code});
            repeat (3) @(posedge clk);
            chk("boot mv", (boot_code == 8'h00) ? 16'h0000 : (t == 1)
                ? 16'(480 + 10 * boot_code) : 16'(240 + 5 * boot_code), boot_mv);
        end
        $display("test boot voltage done");
        for (int c = 0; c < 8; c++) begin
            host.wr(8'he3, 16'(8'h80 + c));
            max_dev_amps <= (c < 7) ? 8'(amps[c]) : 8'hff;
            clr_status();
            repeat (3) @(posedge clk);
            chk("imbalance at limit", 16'h0000, {15'h0, imb_status});
            max_dev_amps <= (c < 7) ? 8'(amps[c] + 1) : 8'hff;
            repeat (3) @(posedge clk);
            chk("imbalance over", 16'(c < 7), {15'h0, imb_status});
            chk("alert", 16'(c < 7), {15'h0, bus_alert_line});
            max_dev_amps <= 8'h00;
        end
        chk("phase kept", 16'h0000, {10'h0, phase_off});
        host.wr(8'he3, 16'h0000);
        max_dev_amps <= 8'h03;
        repeat (3) @(posedge clk);
        chk("phase off", 16'h0002, {10'h0, phase_off});
        max_dev_amps <= 8'h00;
        clr_status();
        $display("test imbalance done");
        host.wr(8'he4, 16'h0003);
        repeat (3) @(posedge clk);
        chk("phase count", 16'h0003, {13'h0, active_phase_code});
        host.wr(8'he4, 16'h0002);
        repeat (3) @(posedge clk);
        chk("phase count", 16'h0002, {13'h0, active_phase_code});
        chk("vendor status", 16'h0000, {15'h0, vendor_status});
        host.wr(8'he4, 16'h0004);
        repeat (3) @(posedge clk);
        chk("phase kept", 16'h0002, {13'h0, active_phase_code});
        chk("vendor status", 16'h0001, {15'h0, vendor_status});
        chk("alert", 16'h0001, {15'h0, bus_alert_line});
        rd_exp(8'he4, 16'h0002);
        $display("test phase limit done");
        for (int w = 0; w < 20 && exp_q.size() > 0; w++) @(posedge clk);
        if (exp_q.size() > 0) bad_count++;
        stop_test();
    end
endmodule : mpfc_regs_tb
